// ### psw_pkg.sv
// constants, register map and carrier types of the pwm waveform block
package psw_pkg;

  // ==========================================================
  // register bus
  localparam int ADDR_W = 4;
  localparam int DATA_W = 8;

  localparam logic [3:0] ADDR_CTRL = 4'h0;
  localparam logic [3:0] ADDR_DB_RISE = 4'h1;
  localparam logic [3:0] ADDR_DB_FALL = 4'h2;
  localparam logic [3:0] ADDR_FRAC = 4'h3;
  localparam logic [3:0] ADDR_STEER = 4'h4;
  localparam logic [3:0] ADDR_STEER2 = 4'h5;
  localparam logic [3:0] ADDR_STATUS = 4'h6;
  localparam logic [3:0] ADDR_FCOUNT = 4'h7;

  // ==========================================================
  // field positions
  localparam int CTRL_MODE_LSB = 0;
  localparam int CTRL_MODE_MSB = 2;
  localparam int CTRL_DBR_EN = 3;
  localparam int CTRL_DBF_EN = 4;
  localparam int STR2_HS_EN = 0;
  localparam int STR2_LS_EN = 1;
  localparam int STAT_DB_BUSY = 6;
  localparam int STAT_QUAL = 7;

  // ==========================================================
  // reset values
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [5:0] RST_STEER = 6'h00;
  localparam logic [3:0] RST_NIBBLE = 4'h0;

  // ==========================================================
  // mode codes held in the control register
  localparam logic [2:0] MODE_OFF = 3'h0;
  localparam logic [2:0] MODE_SKIP_SINGLE = 3'h1;
  localparam logic [2:0] MODE_SKIP_COMP = 3'h2;
  localparam logic [2:0] MODE_FB_FWD = 3'h3;
  localparam logic [2:0] MODE_FB_REV = 3'h4;
  localparam logic [2:0] MODE_VF_SINGLE = 3'h5;
  localparam logic [2:0] MODE_VF_COMP = 3'h6;
  localparam logic [2:0] MODE_THREE_PH = 3'h7;

  // ==========================================================
  // types
  typedef enum logic [2:0] {
    PSW_OFF, PSW_SKIP_SINGLE, PSW_SKIP_COMP, PSW_FB_FWD,
    PSW_FB_REV, PSW_VF_SINGLE, PSW_VF_COMP, PSW_THREE_PH
  } psw_mode_e;

  typedef enum logic [1:0] {DB_IDLE, DB_RISE, DB_FALL} psw_db_e;

  typedef struct packed {
    logic [3:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } psw_bus_s;

  typedef struct packed {
    logic period;
    logic rise;
    logic fall;
    logic rise_src;
  } psw_events_s;

  // bit 0 is output_a
  typedef struct packed {
    logic output_f;
    logic output_e;
    logic output_d;
    logic output_c;
    logic output_b;
    logic output_a;
  } psw_pins_s;

endpackage

// ### psw_wave.sv
// waveform generation for one switch-mode pwm instance
//
// Implementation choices: the register addresses and strobed register access.
`timescale 1ns/1ns

module psw_wave (
  input wire mclk,
  input wire rst,
  input psw_pkg::psw_bus_s bus,
  input psw_pkg::psw_events_s ev,
  output logic [7:0] rdata,
  output psw_pkg::psw_pins_s pins,
  output logic frac_carry
);

  // ==========================================================
  // decoding helpers
  function automatic psw_pkg::psw_mode_e decode_mode(
    input logic [2:0] c
  );
    decode_mode = psw_pkg::PSW_OFF;
    unique case (c)
      psw_pkg::MODE_OFF: decode_mode = psw_pkg::PSW_OFF;
      psw_pkg::MODE_SKIP_SINGLE: decode_mode = psw_pkg::PSW_SKIP_SINGLE;
      psw_pkg::MODE_SKIP_COMP: decode_mode = psw_pkg::PSW_SKIP_COMP;
      psw_pkg::MODE_FB_FWD: decode_mode = psw_pkg::PSW_FB_FWD;
      psw_pkg::MODE_FB_REV: decode_mode = psw_pkg::PSW_FB_REV;
      psw_pkg::MODE_VF_SINGLE: decode_mode = psw_pkg::PSW_VF_SINGLE;
      psw_pkg::MODE_VF_COMP: decode_mode = psw_pkg::PSW_VF_COMP;
      psw_pkg::MODE_THREE_PH: decode_mode = psw_pkg::PSW_THREE_PH;
    endcase
  endfunction

  // lowest set steering bit wins, so stray extra bits stay harmless
  function automatic logic [5:0] low_bit(input logic [5:0] s);
    low_bit = s & 6'(~s + 6'h01);
  endfunction

  // high-side output of the chosen pair (a, c, e)
  function automatic logic [5:0] tp_high(input logic [5:0] s);
    tp_high = 6'h00;
    unique case (low_bit(s))
      6'h01, 6'h02: tp_high = 6'h01;
      6'h04, 6'h08: tp_high = 6'h04;
      6'h10, 6'h20: tp_high = 6'h10;
      default: tp_high = 6'h00;
    endcase
  endfunction

  // low-side output of the chosen pair (b, d, f)
  function automatic logic [5:0] tp_low(input logic [5:0] s);
    tp_low = 6'h00;
    unique case (low_bit(s))
      6'h01, 6'h20: tp_low = 6'h08;
      6'h02, 6'h04: tp_low = 6'h20;
      6'h08, 6'h10: tp_low = 6'h02;
      default: tp_low = 6'h00;
    endcase
  endfunction

  // ==========================================================
  // software registers
  logic [7:0] ctrl;
  logic [7:0] db_rise_time;
  logic [7:0] db_fall_time;
  logic [3:0] frac_adj;
  logic [5:0] steer;
  logic hs_en;
  logic ls_en;

  always_ff @(posedge mclk) begin
    if (rst) begin
      ctrl <= psw_pkg::RST_BYTE;
      db_rise_time <= psw_pkg::RST_BYTE;
      db_fall_time <= psw_pkg::RST_BYTE;
      frac_adj <= psw_pkg::RST_NIBBLE;
      steer <= psw_pkg::RST_STEER;
      hs_en <= 1'b0;
      ls_en <= 1'b0;
    end else if (bus.wr) begin
      unique case (bus.addr)
        psw_pkg::ADDR_CTRL: ctrl <= bus.wdata;
        psw_pkg::ADDR_DB_RISE: db_rise_time <= bus.wdata;
        psw_pkg::ADDR_DB_FALL: db_fall_time <= bus.wdata;
        psw_pkg::ADDR_FRAC: frac_adj <= bus.wdata[3:0];
        psw_pkg::ADDR_STEER: steer <= bus.wdata[5:0];
        psw_pkg::ADDR_STEER2: begin
          hs_en <= bus.wdata[psw_pkg::STR2_HS_EN];
          ls_en <= bus.wdata[psw_pkg::STR2_LS_EN];
        end
        default: ;
      endcase
    end
  end

  // ==========================================================
  // mode decode
  psw_pkg::psw_mode_e mode;
  logic skip_mode;
  logic vf_mode;
  logic comp_mode;
  logic fb_mode;
  logic dir_req;

  assign mode = decode_mode(
    ctrl[psw_pkg::CTRL_MODE_MSB:psw_pkg::CTRL_MODE_LSB]);
  assign skip_mode = (mode == psw_pkg::PSW_SKIP_SINGLE) ||
                     (mode == psw_pkg::PSW_SKIP_COMP);
  assign vf_mode = (mode == psw_pkg::PSW_VF_SINGLE) ||
                   (mode == psw_pkg::PSW_VF_COMP);
  // only the complementary modes offer dead band on events
  assign comp_mode = (mode == psw_pkg::PSW_SKIP_COMP) ||
                     (mode == psw_pkg::PSW_VF_COMP);
  assign fb_mode = (mode == psw_pkg::PSW_FB_FWD) ||
                   (mode == psw_pkg::PSW_FB_REV);
  assign dir_req = (mode == psw_pkg::PSW_FB_REV);

  // ==========================================================
  // pulse qualification
  // source caught at period; a phase-derived one would be constant
  logic qual;
  logic set_evt;
  logic clr_evt;
  logic lvl;

  always_ff @(posedge mclk) begin
    if (rst) begin
      qual <= 1'b0;
    end else if (!skip_mode) begin
      qual <= 1'b0;
    end else if (ev.period) begin
      qual <= ev.rise_src;
    end else if (set_evt) begin
      qual <= 1'b0;
    end
  end

  // ==========================================================
  // event selection per mode
  always_comb begin
    set_evt = 1'b0;
    clr_evt = 1'b0;
    unique case (mode)
      psw_pkg::PSW_OFF: ;
      psw_pkg::PSW_SKIP_SINGLE, psw_pkg::PSW_SKIP_COMP: begin
        set_evt = ev.rise && qual;
        clr_evt = ev.fall;
      end
      psw_pkg::PSW_VF_SINGLE, psw_pkg::PSW_VF_COMP: begin
        set_evt = ev.period && !lvl;
        clr_evt = ev.period && lvl;
      end
      psw_pkg::PSW_FB_FWD, psw_pkg::PSW_FB_REV, psw_pkg::PSW_THREE_PH: begin
        set_evt = ev.rise;
        clr_evt = ev.fall;
      end
    endcase
  end

  // modulated level; a fall beside a rise wins, off is safe for the stage
  always_ff @(posedge mclk) begin
    if (rst) begin
      lvl <= 1'b0;
    end else if (mode == psw_pkg::PSW_OFF || clr_evt) begin
      lvl <= 1'b0;
    end else if (set_evt) begin
      lvl <= 1'b1;
    end
  end

  // ==========================================================
  // dead band
  psw_pkg::psw_db_e db_st;
  logic [7:0] dbc;
  logic [7:0] db_limit;
  logic db_done;
  logic fb_dir;

  assign db_limit = (db_st == psw_pkg::DB_RISE) ? db_rise_time
                                                 : db_fall_time;
  assign db_done = (db_st != psw_pkg::DB_IDLE) && (dbc == db_limit);

  // in the complementary modes a new event terminates any running count and restarts (overlap cases)
  always_ff @(posedge mclk) begin
    if (rst) begin
      db_st <= psw_pkg::DB_IDLE;
      dbc <= psw_pkg::RST_BYTE;
    end else if (comp_mode && clr_evt) begin
      db_st <= ctrl[psw_pkg::CTRL_DBF_EN] ? psw_pkg::DB_FALL
                                          : psw_pkg::DB_IDLE;
      dbc <= psw_pkg::RST_BYTE;
    end else if (comp_mode && set_evt) begin
      db_st <= ctrl[psw_pkg::CTRL_DBR_EN] ? psw_pkg::DB_RISE
                                          : psw_pkg::DB_IDLE;
      dbc <= psw_pkg::RST_BYTE;
    end else if (fb_mode && db_st == psw_pkg::DB_IDLE &&
                 dir_req != fb_dir) begin
      db_st <= dir_req ? psw_pkg::DB_FALL : psw_pkg::DB_RISE;
      dbc <= psw_pkg::RST_BYTE;
    end else if (!(comp_mode || fb_mode) || db_done) begin
      db_st <= psw_pkg::DB_IDLE;
      dbc <= psw_pkg::RST_BYTE;
    end else if (db_st != psw_pkg::DB_IDLE) begin
      dbc <= 8'(dbc + 8'h01);
    end
  end

  // bridge direction only changes once its dead time has run out
  always_ff @(posedge mclk) begin
    if (rst) begin
      fb_dir <= 1'b0;
    end else if (fb_mode && db_done) begin
      fb_dir <= dir_req;
    end
  end

  // ==========================================================
  // fractional frequency counter
  logic [3:0] ffc;

  always_ff @(posedge mclk) begin
    if (rst) begin
      ffc <= psw_pkg::RST_NIBBLE;
      frac_carry <= 1'b0;
    end else if (vf_mode && ev.period) begin
      {frac_carry, ffc} <= {1'b0, ffc} + {1'b0, frac_adj};
    end else begin
      frac_carry <= 1'b0;
    end
  end

  // ==========================================================
  // output mapping
  logic prim;
  logic comp;
  logic [5:0] next_out;
  logic [5:0] tp_hi;
  logic [5:0] tp_lo;
  logic hi_drive;
  logic lo_drive;

  assign prim = lvl && (db_st != psw_pkg::DB_RISE);
  assign comp = !lvl && (db_st != psw_pkg::DB_FALL);
  assign tp_hi = tp_high(steer);
  assign tp_lo = tp_low(steer);
  // an unmodulated side sits at its rising-event state
  assign hi_drive = hs_en ? lvl : 1'b1;
  assign lo_drive = ls_en ? lvl : 1'b1;

  always_comb begin
    next_out = 6'h00;
    unique case (mode)
      psw_pkg::PSW_OFF: ;
      psw_pkg::PSW_SKIP_SINGLE, psw_pkg::PSW_VF_SINGLE: begin
        next_out[0] = lvl;
      end
      psw_pkg::PSW_SKIP_COMP, psw_pkg::PSW_VF_COMP: begin
        next_out[0] = prim;
        next_out[1] = comp;
      end
      psw_pkg::PSW_FB_FWD, psw_pkg::PSW_FB_REV: begin
        // all four off while the direction dead time runs
        if (db_st == psw_pkg::DB_IDLE && fb_dir == dir_req) begin
          if (!fb_dir) begin
            next_out[0] = lvl;
            next_out[3] = 1'b1;
          end else begin
            next_out[1] = lvl;
            next_out[2] = 1'b1;
          end
        end
      end
      psw_pkg::PSW_THREE_PH: begin
        next_out = (tp_hi & {6{hi_drive}}) |
                   (tp_lo & {6{lo_drive}});
      end
    endcase
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      pins <= psw_pkg::psw_pins_s'(6'h00);
    end else begin
      pins <= psw_pkg::psw_pins_s'(next_out);
    end
  end

  // ==========================================================
  // register read port, data only in the cycle after the strobe
  logic [7:0] status;

  assign status = {qual, db_st != psw_pkg::DB_IDLE, 6'(pins)};

  always_ff @(posedge mclk) begin
    if (rst || !bus.rd) begin
      rdata <= psw_pkg::RST_BYTE;
    end else begin
      unique case (bus.addr)
        psw_pkg::ADDR_CTRL: rdata <= ctrl;
        psw_pkg::ADDR_DB_RISE: rdata <= db_rise_time;
        psw_pkg::ADDR_DB_FALL: rdata <= db_fall_time;
        psw_pkg::ADDR_FRAC: rdata <= {4'h0, frac_adj};
        psw_pkg::ADDR_STEER: rdata <= {2'h0, steer};
        psw_pkg::ADDR_STEER2: rdata <= {6'h00, ls_en, hs_en};
        psw_pkg::ADDR_STATUS: rdata <= status;
        psw_pkg::ADDR_FCOUNT: rdata <= {4'h0, ffc};
        default: rdata <= psw_pkg::RST_BYTE;
      endcase
    end
  end

  // ==========================================================
  // checks
  logic [5:0] pins_vec;
  assign pins_vec = 6'(pins);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  sequence s_armed;
    mode == psw_pkg::PSW_SKIP_SINGLE && ev.period && ev.rise_src;
  endsequence
  sequence s_fire;
    mode == psw_pkg::PSW_SKIP_SINGLE && ev.rise && !ev.fall &&
      !ev.period;
  endsequence
  chk_single_pin_a: assert property (
    mode == psw_pkg::PSW_SKIP_SINGLE |=> pins_vec[5:1] == 5'h00)
    else $error("single pulse-skip drove an output other than a");
  chk_skip_fire: assert property (
    s_armed ##1 s_fire |=> ##1 pins.output_a)
    else $error("qualified pulse did not appear on output a");
  chk_skip_miss: assert property (
    (mode == psw_pkg::PSW_SKIP_SINGLE && ev.rise && !qual && !lvl)
      |=> ##1 !pins.output_a)
    else $error("unqualified period produced a pulse");
  chk_comp_break: assert property (
    !(pins.output_a && pins.output_b))
    else $error("primary and complement active together");
  chk_rise_dead: assert property (
    (comp_mode && db_st == psw_pkg::DB_RISE) |=> !pins.output_a)
    else $error("primary raised during rising dead time");
  chk_db_step: assert property (
    (comp_mode && db_st != psw_pkg::DB_IDLE && !db_done && !set_evt &&
      !clr_evt) |=> dbc == 8'($past(dbc) + 8'h01))
    else $error("dead-band counter did not advance by one");
  chk_fb_switch: assert property (
    (mode == psw_pkg::PSW_FB_REV && !fb_dir &&
      db_st == psw_pkg::DB_IDLE) |=> db_st == psw_pkg::DB_FALL)
    else $error("reverse switch did not use falling dead time");
  chk_fb_forward: assert property (
    (mode == psw_pkg::PSW_FB_FWD && !fb_dir && db_st == psw_pkg::DB_IDLE)
      |=> pins.output_d && !pins.output_b && !pins.output_c)
    else $error("forward bridge static outputs wrong");
  chk_fb_reverse: assert property (
    (mode == psw_pkg::PSW_FB_REV && fb_dir && db_st == psw_pkg::DB_IDLE)
      |=> pins.output_c && !pins.output_a && !pins.output_d)
    else $error("reverse bridge static outputs wrong");
  chk_vf_toggle: assert property (
    (mode == psw_pkg::PSW_VF_SINGLE && ev.period) |=> lvl != $past(lvl))
    else $error("period event did not toggle output level");
  chk_frac_add: assert property (
    (vf_mode && ev.period) |=> ffc == 4'($past(ffc) + $past(frac_adj)))
    else $error("fractional counter not stepped by adjust value");
  chk_tp_pair: assert property (
    mode == psw_pkg::PSW_THREE_PH |=> $countones(pins_vec) <= 2)
    else $error("more than two three-phase outputs active");
  chk_tp_static: assert property (
    (mode == psw_pkg::PSW_THREE_PH && steer == 6'h01 && !hs_en && !ls_en)
      |=> pins_vec == 6'h09)
    else $error("steering 01 did not hold a and d active");
  chk_tp_lowest: assert property (
    (mode == psw_pkg::PSW_THREE_PH && steer == 6'h0c && !hs_en && !ls_en)
      |=> pins_vec == 6'h24)
    else $error("lowest steering bit did not choose the pair");
endmodule

// ### psw_bridge_model.sv
// behavioural model of the three half-bridge driver stages on the pins
`timescale 1ns/1ns

// ==========================================================
// half-bridge driver stages
// legs: a/b phase one, c/d phase two, e/f phase three
module psw_bridge_model (
  input wire mclk,
  input psw_pkg::psw_pins_s pins,
  output int shoot_thru
);
  // a leg with both switches on shorts the rail; a real stage would burn,
  // the model only counts the cycles so the bench can report them
  always @(posedge mclk) begin
    if ((pins.output_a & pins.output_b) === 1'b1 ||
        (pins.output_c & pins.output_d) === 1'b1 ||
        (pins.output_e & pins.output_f) === 1'b1) begin
      shoot_thru <= shoot_thru + 1;
    end
  end
endmodule

// ### test_switch_mode_pwm_waveform_modes.sv
// self-checking bench of the pwm waveform block
`timescale 1ns/1ns

`define CHK(got, exp) begin checks_done++; if ((got) !== (exp)) begin \
  n_fail++; $display("Error %0t ns: got %h expected %h", $time, got, exp); \
  end end

module test_switch_mode_pwm_waveform_modes;
  // ==========================================================
  // signals
  typedef struct packed {logic [5:0] steer; logic [5:0] exp;} psw_row_s;
  localparam psw_pkg::psw_events_s EV_PER = 4'h8;
  localparam psw_pkg::psw_events_s EV_PQ = 4'h9;
  localparam psw_pkg::psw_events_s EV_RISE = 4'h4;
  localparam psw_pkg::psw_events_s EV_FALL = 4'h2;
  localparam psw_pkg::psw_events_s EV_BOTH = 4'h6;
  logic mclk = 1'b0;
  logic rst = 1'b1;
  psw_pkg::psw_bus_s bus = '0;
  psw_pkg::psw_events_s ev = '0;
  logic [7:0] rdata;
  psw_pkg::psw_pins_s pins;
  logic frac_carry;
  logic p0;
  int n_fail = 0;
  int checks_done = 0;
  int n_carry = 0;
  int shoot_thru;
  psw_row_s rows [11] = '{'{6'h00, 6'h00}, '{6'h01, 6'h09}, '{6'h02, 6'h21},
    '{6'h04, 6'h24}, '{6'h08, 6'h06}, '{6'h10, 6'h12}, '{6'h20, 6'h18},
    '{6'h0c, 6'h24}, '{6'h30, 6'h12}, '{6'h3f, 6'h09}, '{6'h28, 6'h06}};
  logic [3:0] wa [5] = '{psw_pkg::ADDR_STEER, psw_pkg::ADDR_STEER2,
    psw_pkg::ADDR_FRAC, psw_pkg::ADDR_DB_RISE, psw_pkg::ADDR_DB_FALL};
  logic [7:0] wd [5] = '{8'hff, 8'hff, 8'hff, 8'h02, 8'h06};
  logic [7:0] we [5] = '{8'h3f, 8'h03, 8'h0f, 8'h02, 8'h06};

  always #50 mclk = ~mclk;

  always @(posedge mclk) begin
    if (frac_carry === 1'b1) begin
      n_carry++;
    end
  end

  psw_wave uut (.mclk(mclk), .rst(rst), .bus(bus), .ev(ev), .rdata(rdata),
    .pins(pins), .frac_carry(frac_carry));
  psw_bridge_model drv (.mclk(mclk), .pins(pins), .shoot_thru(shoot_thru));

  // ==========================================================
  // bus and event tasks
  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
  endtask

  task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
    @(posedge mclk);
    bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge mclk);
    bus.wr <= 1'b0;
  endtask

  // read data stand only in the cycle after the strobe
  task automatic rd_chk(input logic [3:0] a, input logic [7:0] exp);
    @(posedge mclk);
    bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge mclk);
    bus.rd <= 1'b0;
    #1;
    `CHK(rdata, exp)
  endtask

  // pins follow an event one cycle after the edge that takes it
  task automatic pulse(input psw_pkg::psw_events_s e);
    @(posedge mclk);
    ev <= e;
    @(posedge mclk);
    ev <= '0;
    tick(2);
    #1;
  endtask

  // waits for a target pattern, counting the all-off cycles on the way
  task automatic meas(input logic [5:0] exp, input int n);
    int nz;
    nz = 0;
    #1;
    for (int i = 0; i < 40 && pins !== exp; i++) begin
      if (pins === 6'h00) begin
        nz++;
      end
      @(posedge mclk);
      #1;
    end
    `CHK(pins, exp)
    `CHK((nz >= n && nz <= n + 2), 1'b1)
  endtask

  task automatic db_step(input psw_pkg::psw_events_s e,
                         input logic [5:0] exp, input int n);
    pulse(e);
    meas(exp, n);
  endtask

  task automatic final_report;
    if (n_fail == 0 && checks_done > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // ==========================================================
  // watchdog
  initial begin
    #2000000;
    n_fail++;
    final_report();
  end

  // ==========================================================
  // main sequence
  initial begin
    tick(16);
    #1;
    `CHK(pins, 6'h00)
    @(posedge mclk);
    rst <= 1'b0;
    wr_reg(psw_pkg::ADDR_CTRL, {5'h00, psw_pkg::MODE_THREE_PH});
    foreach (rows[i]) begin
      wr_reg(psw_pkg::ADDR_STEER, {2'b00, rows[i].steer});
      tick(4);
      #1;
      `CHK(pins, rows[i].exp)
    end
    // side modulation with steering on pair a/d
    wr_reg(psw_pkg::ADDR_STEER, 8'h01);
    for (int m = 1; m < 4; m++) begin
      wr_reg(psw_pkg::ADDR_STEER2, 8'(m));
      pulse(EV_FALL);
      `CHK(pins, 6'h09 & ~{2'b00, m[1], 2'b00, m[0]})
      pulse(EV_RISE);
      `CHK(pins, 6'h09)
    end
    // reset in mid-run clears outputs and registers
    @(posedge mclk);
    rst <= 1'b1;
    tick(2);
    #1;
    `CHK(pins, 6'h00)
    @(posedge mclk);
    rst <= 1'b0;
    for (int a = 0; a < 16; a++) begin
      rd_chk(a[3:0], 8'h00);
    end
    wr_reg(psw_pkg::ADDR_STATUS, 8'hff);
    wr_reg(psw_pkg::ADDR_FCOUNT, 8'hff);
    wr_reg(4'h9, 8'hff);
    rd_chk(psw_pkg::ADDR_STATUS, 8'h00);
    rd_chk(psw_pkg::ADDR_FCOUNT, 8'h00);
    rd_chk(4'h9, 8'h00);
    for (int i = 0; i < 5; i++) begin
      wr_reg(wa[i], wd[i]);
      rd_chk(wa[i], we[i]);
    end
    // single pulse skipping, source fed externally
    wr_reg(psw_pkg::ADDR_CTRL, {5'h00, psw_pkg::MODE_SKIP_SINGLE});
    pulse(EV_PER);
    pulse(EV_RISE);
    `CHK(pins, 6'h00)
    pulse(EV_PQ);
    pulse(EV_RISE);
    `CHK(pins, 6'h01)
    pulse(EV_FALL);
    `CHK(pins, 6'h00)
    // qualifying period directly followed by the synchronous rise
    @(posedge mclk);
    ev <= EV_PQ;
    @(posedge mclk);
    ev <= EV_RISE;
    pulse(EV_RISE);
    `CHK(pins, 6'h01)
    pulse(EV_FALL);
    `CHK(pins, 6'h00)
    // complementary pulse skipping, rise time 2, fall time 6
    wr_reg(psw_pkg::ADDR_CTRL, {5'h03, psw_pkg::MODE_SKIP_COMP});
    pulse(EV_PQ);
    rd_chk(psw_pkg::ADDR_STATUS, 8'h82);
    db_step(EV_RISE, 6'h01, 2);
    db_step(EV_FALL, 6'h02, 6);
    // full bridge, dead time only on a change of direction
    wr_reg(psw_pkg::ADDR_CTRL, {5'h00, psw_pkg::MODE_FB_FWD});
    tick(4);
    #1;
    `CHK(pins, 6'h08)
    pulse(EV_RISE);
    `CHK(pins, 6'h09)
    pulse(EV_BOTH);
    `CHK(pins, 6'h08)
    wr_reg(psw_pkg::ADDR_CTRL, {5'h00, psw_pkg::MODE_FB_REV});
    meas(6'h04, 6);
    pulse(EV_RISE);
    `CHK(pins, 6'h06)
    pulse(EV_FALL);
    `CHK(pins, 6'h04)
    wr_reg(psw_pkg::ADDR_CTRL, {5'h00, psw_pkg::MODE_FB_FWD});
    meas(6'h08, 2);
    // variable frequency, single output, adjust 5
    wr_reg(psw_pkg::ADDR_FRAC, 8'h05);
    wr_reg(psw_pkg::ADDR_CTRL, {5'h00, psw_pkg::MODE_VF_SINGLE});
    tick(4);
    #1;
    p0 = pins.output_a;
    for (int k = 1; k < 5; k++) begin
      pulse(EV_PER);
      `CHK(pins, {5'h00, p0 ^ k[0]})
      rd_chk(psw_pkg::ADDR_FCOUNT, {4'h0, 4'(5 * k)});
    end
    `CHK(n_carry, 1)
    pulse(EV_RISE);
    pulse(EV_FALL);
    `CHK(pins, {5'h00, p0})
    // variable frequency, complementary
    wr_reg(psw_pkg::ADDR_CTRL, {5'h03, psw_pkg::MODE_VF_COMP});
    tick(8);
    #1;
    p0 = pins.output_a;
    for (int j = 0; j < 2; j++) begin
      if ((p0 ^ j[0]) == 1'b1) begin
        db_step(EV_PER, 6'h02, 6);
      end else begin
        db_step(EV_PER, 6'h01, 2);
      end
    end
    wr_reg(psw_pkg::ADDR_CTRL, 8'h00);
    tick(4);
    #1;
    `CHK(pins, 6'h00)
    `CHK(shoot_thru, 0)
    final_report();
  end
endmodule
